/* core/tebc_timer_enable_bo.v */
// Timer enable register bank with brown-out driven global reset and power-on sequence.
// Assumes one 25 MHz clock, asynchronous active-high reset, comparator and low-voltage
// inputs synchronous to the clock, and a register port with read data one cycle later.
//
// What this block does
// - Reserved bits 7..3 of the timer enable register ignore writes and always read as ones.
// - The sync mode bit enables synchronised timer operation when set, clears on reset and survives stop-mode recovery.
// - Each timer enable bit reads back whether its timer runs, a written 0 stops it, a 1 starts it, reset stops it.
// - Global reset is held for as long as the comparator reports the supply below the brown-out threshold.
// - When the supply returns above the threshold a full power-on reset sequence runs before normal operation.
`include "tebc_map.vh"
`timescale 1ns/100ps
`default_nettype none

module tebc_timer_enable_bo #(
  parameter POR_CYCLES = `TEBC_POR_CYCLES
) (
  input wire clock,
  input wire reset,
  input wire stop_recovery,
  input wire supply_below_threshold,
  input wire low_voltage_detect,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  output reg [7:0] reg_rdata,
  output reg narrow_timer_run,
  output reg wide_timer_run,
  output reg sync_mode,
  output reg [7:0] wide_timer_control,
  output reg [7:0] port_three_mode,
  output reg global_reset,
  output reg irq
);

  // ==========================================
  // Power sequencing states
  localparam [1:0] ST_RUN = 2'b00;
  localparam [1:0] ST_BROWN = 2'b01;
  localparam [1:0] ST_POR = 2'b10;

  // Power-on stretch load value and decrement step
  localparam [`TEBC_POR_CNT_W-1:0] POR_LOAD = POR_CYCLES[`TEBC_POR_CNT_W-1:0];
  localparam [`TEBC_POR_CNT_W-1:0] CNT_ONE = {{(`TEBC_POR_CNT_W-1){1'b0}}, 1'b1};

  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [`TEBC_POR_CNT_W-1:0] por_cnt_q;
  reg [`TEBC_POR_CNT_W-1:0] por_cnt_d;
  reg low_flag_q;
  reg low_flag_d;
  reg [`TEBC_IRQ_BITS-1:0] irq_stat_q;
  wire [`TEBC_IRQ_BITS-1:0] irq_stat_d;
  reg [`TEBC_IRQ_BITS-1:0] irq_mask_q;
  reg [`TEBC_IRQ_BITS-1:0] irq_mask_d;
  reg [`TEBC_IRQ_BITS-1:0] irq_event;
  reg irq_d;
  reg narrow_run_d;
  reg wide_run_d;
  reg sync_d;
  reg [7:0] wide_ctl_d;
  reg [7:0] p3_mode_d;
  reg [7:0] rdata_d;
  wire sys_rst;
  wire wr_en;
  wire wr_tmr_en;
  wire wr_wide_ctl;
  wire wr_p3_mode;
  wire wr_irq_mask;
  wire rd_vdet;
  wire rd_irq_stat;
  wire bo_entry;
  wire por_exit;
  wire [7:0] en_status;
  wire [7:0] vdet_status;

  function hit;
    input [7:0] a;
    input [7:0] target;
    begin
      hit = (a == target);
    end
  endfunction

  // Block-wide reset: pin reset, or brown-out / power-on in progress
  // Widens an interrupt vector to a read byte
  function [7:0] pad_irq;
    input [`TEBC_IRQ_BITS-1:0] v;
    begin
      pad_irq = {{(8-`TEBC_IRQ_BITS){1'b0}}, v};
    end
  endfunction

  assign sys_rst = global_reset;
  assign wr_en = reg_write && !global_reset;

  // Register access decode
  assign wr_tmr_en = wr_en && hit(reg_addr, `TEBC_ADDR_TMR_EN);
  assign wr_wide_ctl = wr_en && hit(reg_addr, `TEBC_ADDR_WIDE_CTL);
  assign wr_p3_mode = wr_en && hit(reg_addr, `TEBC_ADDR_P3_MODE);
  assign wr_irq_mask = wr_en && hit(reg_addr, `TEBC_ADDR_IRQ_MASK);
  assign rd_vdet = reg_read && hit(reg_addr, `TEBC_ADDR_VDET);
  assign rd_irq_stat = reg_read && hit(reg_addr, `TEBC_ADDR_IRQ_STAT);

  // Sequencer events
  assign bo_entry = (state_q != ST_BROWN) && (state_d == ST_BROWN);
  assign por_exit = (state_q == ST_POR) && (state_d == ST_RUN);

  assign vdet_status = {6'h00, (state_q != ST_RUN), low_flag_q};

  assign en_status = {`TEBC_RSVD_ONES, sync_mode, narrow_timer_run, wide_timer_run};

  // ==========================================
  // Brown-out sequencing
  always @* begin
    state_d = state_q;
    por_cnt_d = por_cnt_q;
    case (state_q)
      ST_RUN: begin
        if (supply_below_threshold) begin
          state_d = ST_BROWN;
        end
      end
      ST_BROWN: begin
        if (!supply_below_threshold) begin
          state_d = ST_POR;
          por_cnt_d = POR_LOAD;
        end
      end
      ST_POR: begin
        if (supply_below_threshold) begin
          state_d = ST_BROWN;
        end else if (por_cnt_q <= CNT_ONE) begin
          state_d = ST_RUN;
        end else begin
          por_cnt_d = por_cnt_q - CNT_ONE;
        end
      end
      default: begin
        state_d = ST_BROWN;
      end
    endcase
  end

  // Pin reset starts the same stretch that a brown-out recovery runs
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      state_q <= ST_POR;
      por_cnt_q <= POR_LOAD;
    end else begin
      state_q <= state_d;
      por_cnt_q <= por_cnt_d;
    end
  end

  // Global reset follows the next state so it rises at the edge that sees low supply
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      global_reset <= 1'b1;
    end else begin
      global_reset <= (state_d != ST_RUN);
    end
  end

  // ==========================================
  // Timer enable and control registers
  always @* begin
    narrow_run_d = narrow_timer_run;
    wide_run_d = wide_timer_run;
    sync_d = sync_mode;
    wide_ctl_d = wide_timer_control;
    p3_mode_d = port_three_mode;
    if (sys_rst) begin
      narrow_run_d = 1'b0;
      wide_run_d = 1'b0;
      sync_d = 1'b0;
      wide_ctl_d = `TEBC_RST_BYTE;
      p3_mode_d = `TEBC_RST_BYTE;
    end else if (stop_recovery) begin
      // Stop-mode recovery keeps sync mode and the port three mode byte
      narrow_run_d = 1'b0;
      wide_run_d = 1'b0;
      wide_ctl_d = `TEBC_RST_BYTE;
    end else begin
      if (wr_tmr_en) begin
        wide_run_d = reg_wdata[`TEBC_BIT_WIDE_EN];
        narrow_run_d = reg_wdata[`TEBC_BIT_NARROW_EN];
        sync_d = reg_wdata[`TEBC_BIT_SYNC];
      end
      if (wr_wide_ctl) begin
        wide_ctl_d = reg_wdata;
      end
      if (wr_p3_mode) begin
        p3_mode_d = reg_wdata;
      end
    end
  end

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      narrow_timer_run <= 1'b0;
      wide_timer_run <= 1'b0;
      sync_mode <= 1'b0;
      wide_timer_control <= `TEBC_RST_BYTE;
      port_three_mode <= `TEBC_RST_BYTE;
    end else begin
      narrow_timer_run <= narrow_run_d;
      wide_timer_run <= wide_run_d;
      sync_mode <= sync_d;
      wide_timer_control <= wide_ctl_d;
      port_three_mode <= p3_mode_d;
    end
  end

  // ==========================================
  // Low-voltage flag and interrupts
  always @* begin
    irq_event = `TEBC_RST_IRQ;
    irq_event[`TEBC_IRQ_BROWNOUT] = bo_entry;
    irq_event[`TEBC_IRQ_RECOVER] = por_exit;
    irq_event[`TEBC_IRQ_LOWV] = low_voltage_detect && !low_flag_q;
  end

  // Each status bit is sticky; a new event wins over the clearing read
  genvar gi;
  generate
    for (gi = 0; gi < `TEBC_IRQ_BITS; gi = gi + 1) begin : g_stat
      assign irq_stat_d[gi] = irq_event[gi] | (irq_stat_q[gi] & !rd_irq_stat);
    end
  endgenerate

  always @* begin
    low_flag_d = low_flag_q;
    irq_mask_d = irq_mask_q;
    // A new detection wins over the clearing read
    if (low_voltage_detect) begin
      low_flag_d = 1'b1;
    end else if (rd_vdet) begin
      low_flag_d = 1'b0;
    end
    if (wr_irq_mask) begin
      irq_mask_d = reg_wdata[`TEBC_IRQ_BITS-1:0];
    end
    irq_d = |(irq_stat_q & irq_mask_q);
  end

  // Brown-out and recovery events are kept through global reset
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      low_flag_q <= 1'b0;
      irq_stat_q <= `TEBC_RST_IRQ;
      irq_mask_q <= `TEBC_RST_IRQ;
      irq <= 1'b0;
    end else begin
      low_flag_q <= low_flag_d;
      irq_stat_q <= irq_stat_d;
      irq_mask_q <= irq_mask_d;
      irq <= irq_d;
    end
  end

  // ==========================================
  // Read data, valid in the cycle after the read strobe
  always @* begin
    rdata_d = `TEBC_RST_BYTE;
    if (reg_read) begin
      case (reg_addr)
        `TEBC_ADDR_TMR_EN: begin
          rdata_d = en_status;
        end
        `TEBC_ADDR_WIDE_CTL: begin
          rdata_d = wide_timer_control;
        end
        `TEBC_ADDR_VDET: begin
          rdata_d = vdet_status;
        end
        `TEBC_ADDR_IRQ_STAT: begin
          rdata_d = pad_irq(irq_stat_q);
        end
        `TEBC_ADDR_IRQ_MASK: begin
          rdata_d = pad_irq(irq_mask_q);
        end
        default: begin
          // Write-only and unmapped addresses read as zero
          rdata_d = `TEBC_RST_BYTE;
        end
      endcase
    end
  end

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      reg_rdata <= `TEBC_RST_BYTE;
    end else begin
      reg_rdata <= rdata_d;
    end
  end

endmodule // tebc_timer_enable_bo

`default_nettype wire

/* core/tebc_map.vh */
// Register offsets, field positions, reset values and timing counts of the timer enable and brown-out block.
// Assumes inclusion by the design file of this block only.
`ifndef TEBC_MAP_VH
`define TEBC_MAP_VH

// ==========================================
// Register offsets
`define TEBC_ADDR_WIDE_CTL 8'h02
`define TEBC_ADDR_TMR_EN 8'h03
`define TEBC_ADDR_VDET 8'h0c
`define TEBC_ADDR_P3_MODE 8'hf7
`define TEBC_ADDR_IRQ_STAT 8'h10
`define TEBC_ADDR_IRQ_MASK 8'h11

// ==========================================
// Field positions of the timer enable register
`define TEBC_BIT_WIDE_EN 0
`define TEBC_BIT_NARROW_EN 1
`define TEBC_BIT_SYNC 2
`define TEBC_RSVD_ONES 5'h1f

// ==========================================
// Field positions of the voltage detect register
`define TEBC_BIT_LV_FLAG 0
`define TEBC_BIT_BO_ACTIVE 1

// ==========================================
// Interrupt status bits
`define TEBC_IRQ_BROWNOUT 0
`define TEBC_IRQ_RECOVER 1
`define TEBC_IRQ_LOWV 2
`define TEBC_IRQ_BITS 3

// ==========================================
// Reset values
`define TEBC_RST_BYTE 8'h00
`define TEBC_RST_IRQ 3'h0

// ==========================================
// Power-on reset stretch after brown-out, in cycles
`define TEBC_POR_CYCLES 16'h0400
`define TEBC_POR_CNT_W 16

`endif

/* test/tebc_timer_enable_bo_assertions.sv */
// Port assertions for the timer enable and brown-out block.
// Assumes binding to tebc_timer_enable_bo; one clock, reset async active high.
`timescale 1ns/100ps
`default_nettype none
module tebc_chk #(parameter POR_CYCLES = 1024) (
  input wire logic clock,
  input wire logic reset,
  input wire logic stop_recovery,
  input wire logic supply_below_threshold,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic narrow_timer_run,
  input wire logic wide_timer_run,
  input wire logic sync_mode,
  input wire logic global_reset
);
  // ==========================================
  // Cycles since the comparator last reported low supply
  logic [15:0] ok_cnt_q;
  always_ff @(posedge clock or posedge reset) begin
    if (reset || supply_below_threshold) ok_cnt_q <= 16'h0000;
    else if (ok_cnt_q != 16'hffff) ok_cnt_q <= ok_cnt_q + 16'h0001;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  logic en_rd;
  assign en_rd = reg_read && reg_addr == 8'h03;
  a_rsvd_ones: assert property (en_rd |=> reg_rdata[7:3] == 5'h1f) else $error("reserved bits");
  a_enable_read: assert property (en_rd |=> reg_rdata[2:0] == {$past(sync_mode), $past(narrow_timer_run),
    $past(wide_timer_run)}) else $error("enable readback");
  a_write_effect: assert property (reg_write && reg_addr == 8'h03 && !global_reset && !supply_below_threshold
    && !stop_recovery |=> {sync_mode, narrow_timer_run, wide_timer_run} == $past(reg_wdata[2:0]))
    else $error("enable write");
  a_stop_keeps: assert property (stop_recovery && !reg_write && !supply_below_threshold && !global_reset |=>
    sync_mode == $past(sync_mode) && !narrow_timer_run && !wide_timer_run) else $error("stop recovery");
  a_bo_reset: assert property (supply_below_threshold |=> global_reset) else $error("brown-out reset");
  a_bo_clears: assert property (global_reset |=> !narrow_timer_run && !wide_timer_run && !sync_mode)
    else $error("reset clear");
  a_por_hold: assert property (ok_cnt_q < POR_CYCLES |-> global_reset) else $error("por short");
  a_por_ends: assert property (ok_cnt_q == POR_CYCLES + 4 |-> !global_reset) else $error("por long");
endmodule // tebc_chk
bind tebc_timer_enable_bo tebc_chk #(.POR_CYCLES(POR_CYCLES)) u_chk (.clock, .reset, .stop_recovery,
  .supply_below_threshold, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .narrow_timer_run,
  .wide_timer_run, .sync_mode, .global_reset);
`default_nettype wire

/* test/tebc_timer_enable_bo_tb_top.sv */
// Self-checking bench for the timer enable and brown-out block.
// Assumes design and checker compiled first; power-on stretch cut to 8 cycles.
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin failures++; $display("FAIL %s exp %h got %h", n, e, g); end end
module tebc_timer_enable_bo_tb_top;
  logic clock, reset, stop_recovery, supply_below_threshold, low_voltage_detect, reg_write, reg_read;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, wide_timer_control, port_three_mode;
  logic narrow_timer_run, wide_timer_run, sync_mode, global_reset, irq;
  int failures, compares, n;
  tebc_timer_enable_bo #(.POR_CYCLES(8)) u_dut (.clock, .reset, .stop_recovery, .supply_below_threshold,
    .low_voltage_detect, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .narrow_timer_run,
    .wide_timer_run, .sync_mode, .wide_timer_control, .port_three_mode, .global_reset, .irq);
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  task automatic tick(input int c);
    repeat (c) @(posedge clock);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 `CHK("reg_rdata", e, reg_rdata)
  endtask
  task automatic give_verdict();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic wait_por(output int c);
    for (c = 0; c < 60 && global_reset !== 1'b0; c++) tick(1);
    if (c == 60) begin
      failures++;
      give_verdict();
    end
  endtask
  initial begin
    {reset, stop_recovery, supply_below_threshold, low_voltage_detect, reg_write, reg_read} = 6'h20;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    repeat (16) @(posedge clock);
    reset <= 1'b0;
    wait_por(n);
    rd(8'h03, 8'hf8);
    $display("test reset done");
    for (n = 0; n < 8; n++) begin
      wr(8'h03, {n[4:0], n[2:0]});
      rd(8'h03, {5'h1f, n[2:0]});
      `CHK("narrow_timer_run", n[1], narrow_timer_run)
      `CHK("sync_mode", n[2], sync_mode)
    end
    wr(8'h02, 8'h5a);
    wr(8'hf7, 8'ha5);
    rd(8'h02, 8'h5a);
    rd(8'hf7, 8'h00);
    rd(8'h55, 8'h00);
    `CHK("port_three_mode", 8'ha5, port_three_mode)
    stop_recovery <= 1'b1;
    tick(1);
    stop_recovery <= 1'b0;
    rd(8'h03, 8'hfc);
    rd(8'h02, 8'h00);
    $display("test enables done");
    supply_below_threshold <= 1'b1;
    tick(3);
    `CHK("global_reset", 1'b1, global_reset)
    wr(8'h03, 8'h07);
    rd(8'h03, 8'hf8);
    supply_below_threshold <= 1'b0;
    wait_por(n);
    `CHK("por_cycles", 1'b1, n >= 8)
    rd(8'h03, 8'hf8);
    $display("test brown-out done");
    wr(8'h11, 8'h01);
    tick(2);
    `CHK("irq", 1'b1, irq)
    rd(8'h10, 8'h03);
    tick(1);
    `CHK("irq", 1'b0, irq)
    low_voltage_detect <= 1'b1;
    tick(2);
    low_voltage_detect <= 1'b0;
    `CHK("irq", 1'b0, irq)
    rd(8'h0c, 8'h01);
    rd(8'h10, 8'h04);
    wr(8'h11, 8'h04);
    low_voltage_detect <= 1'b1;
    tick(3);
    `CHK("irq", 1'b1, irq)
    low_voltage_detect <= 1'b0;
    $display("test interrupts done");
    give_verdict();
  end
endmodule // tebc_timer_enable_bo_tb_top
`default_nettype wire
